// File: rtl/icg_pkg.sv
// shared constants, types and carriers of the clock generator control
package icg_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses on the bus)
    // ------------------------------------------------------------
    localparam logic [7:0] ICG_OFS_CTRL = 8'h00;
    localparam logic [7:0] ICG_OFS_MULT = 8'h04;
    localparam logic [7:0] ICG_OFS_CODE = 8'h08;
    localparam logic [7:0] ICG_OFS_STAT = 8'h0c;

    // control register fields
    localparam int ICG_CTRL_INT_ON = 0;
    localparam int ICG_CTRL_EXT_ON = 1;
    localparam int ICG_CTRL_CLK_SEL = 2;
    // status register fields
    localparam int ICG_STAT_INT_EN = 0;
    localparam int ICG_STAT_EXT_EN = 1;
    localparam int ICG_STAT_STABLE = 2;
    localparam int ICG_STAT_STOP = 3;
    localparam int ICG_STAT_PC4 = 4;
    localparam int ICG_STAT_PC3 = 5;

    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int ICG_MULT_W = 7;
    localparam int ICG_CODE_W = 12;
    localparam logic [ICG_MULT_W-1:0] ICG_MULT_RST = 7'h15;
    localparam logic [ICG_CODE_W-1:0] ICG_CODE_RST = 12'h500;
    localparam logic ICG_INT_ON_RST = 1'b1;

    // oscillator code limits and loop filter steps
    localparam logic [ICG_CODE_W-1:0] ICG_CODE_MAX = 12'h9ff;
    localparam logic [3:0] ICG_DIV_SLOWEST = 4'h9;
    localparam logic [ICG_CODE_W-1:0] ICG_STEP_BIG = 12'h020;
    localparam logic [ICG_CODE_W-1:0] ICG_STEP_MID = 12'h008;
    localparam logic [ICG_CODE_W-1:0] ICG_STEP_FINE = 12'h001;

    // ------------------------------------------------------------
    // frequency comparator result bands
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ICG_BAND_SLOW_FAR = 3'h0,  // below 0.85 nominal
        ICG_BAND_SLOW_MID = 3'h1,  // 0.85 .. 0.95
        ICG_BAND_SLOW_NEAR = 3'h2, // 0.95 .. 1.00
        ICG_BAND_FAST_NEAR = 3'h3, // 1.00 .. 1.05
        ICG_BAND_FAST_MID = 3'h4,  // 1.05 .. 1.15
        ICG_BAND_FAST_FAR = 3'h5   // above 1.15
    } icg_band_e;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic keep_osc_in_stop;
        logic ext_clock_allowed;
        logic crystal_mode_enable;
    } icg_cfg_s;

    typedef struct packed {
        logic internal_clock;
        logic external_clock;
        logic base_clock;
        logic osc_out_clock;
        logic gen_out_clock;
        logic timebase_clock;
    } icg_clk_s;

    typedef struct packed {
        logic [2:0] sh;   // sh[0] first stage
        logic filt;
        logic prev;
    } icg_sync_s;

    typedef struct packed {
        icg_sync_s controlled_oscillator;
        icg_sync_s osc1;
        icg_sync_s done;
        logic int_on;
        logic ext_on;
        logic clk_sel;
        logic [ICG_MULT_W-1:0] mult;
        logic [ICG_CODE_W-1:0] code;
        logic stable;
        logic [ICG_MULT_W-1:0] div_cnt;
        icg_clk_s clk;
        logic ap_valid;
        logic ap_write;
        logic [7:0] ap_addr;
        logic [31:0] rdata;
    } icg_state_s;

endpackage

// File: rtl/icg_ctrl.sv
// clock generator control: enables, base divider, loop filter, selection
//
// Behaviour
// R1: gen output clock runs at half the oscillator output clock.
// R2: stop mode with keep_osc_in_stop clear asserts stop, halting all clocks.
// R3: keep_osc_in_stop set keeps stop deasserted in stop mode.
// R4: int_gen_enable equals int_gen_on_bit and not stop.
// R5: int_gen_enable low holds internal and base clocks low.
// R6: ext_gen_enable equals ext_gen_on_bit and not stop; else external low.
// R7: setting ext_gen_on_bit ignored unless external clock allowed.
// R8: pin C4 port enable low whenever ext_gen_on_bit set, stop ignored.
// R9: pin C3 port enable low when ext on and crystal mode both set.
// R10: base clock is internal clock divided by multiplier factor.
// R11: multiplier zero or one bypasses divider, internal passes straight.
// R12: 12-bit code is divider nibble above stage byte, 000 to 9FF.
// R13: loop filter adds or subtracts correction from measured period error.
// R14: below 0.85 nominal subtract 32; above 1.15 add 32.
// R15: 0.85 to 0.95 subtract 8; 1.05 to 1.15 add 8.
// R16: 0.95 to nominal subtract 1; nominal to 1.05 add 1.
// R17: correction is 12-bit arithmetic, carry and borrow reach divider.
// R18: divider nibble A to F treated as 9, the slowest.
// R19: wrapped code recovers only through ordinary subtracting steps.
// R20: filter stable flag set when error within five percent.
// R21: oscillator output from external when select set, else internal.
// R22: one correction per measurement; stable flag follows latest one.
`timescale 1ns/1ps

module icg_ctrl
    import icg_pkg::*;
(
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // ahb-lite slave
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    // system and configuration
    input wire logic i_stop_mode,
    input wire icg_cfg_s i_cfg,
    // raw oscillator and comparator signals (asynchronous)
    input wire logic i_dco_raw,
    input wire logic i_osc1_raw,
    input wire logic i_cmp_done_tgl,
    input wire logic [2:0] i_cmp_band,
    // generator enables and port handover
    output logic o_gen_stop_signal,
    output logic o_int_gen_enable,
    output logic o_ext_gen_enable,
    output logic o_pin_c4_port_enable,
    output logic o_pin_c3_port_enable,
    // oscillator code and filter status
    output logic [3:0] o_osc_divider_code,
    output logic [7:0] o_osc_stage_code,
    output logic [3:0] o_osc_divider_eff,
    output logic o_filter_stable_flag,
    // generated clocks (levels on the system clock grid)
    output icg_clk_s o_clk
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    icg_state_s s_r;
    icg_state_s s_nxt;

    // ------------------------------------------------------------
    // combinational helpers
    // ------------------------------------------------------------
    logic gen_stop;
    logic int_en;
    logic ext_en;

    // R2: stop halts the generator
    // R3: unless oscillator kept alive in stop
    assign gen_stop = i_stop_mode & ~i_cfg.keep_osc_in_stop;
    // R4: internal generator enable
    assign int_en = s_r.int_on & ~gen_stop;
    // R6: external generator enable
    assign ext_en = s_r.ext_on & ~gen_stop;

    // three-stage synchroniser step, filtered on stages two and three
    function automatic icg_sync_s sync_step(input icg_sync_s cur,
                                            input logic pin);
        icg_sync_s r;
        r = cur;
        r.sh = {cur.sh[1:0], pin};
        r.prev = cur.filt;
        if (cur.sh[1] == cur.sh[2]) begin
            r.filt = cur.sh[2];
        end
        return r;
    endfunction

    // loop filter step chosen from the comparator band
    function automatic logic [ICG_CODE_W-1:0] corr_of(input logic [2:0] b);
        logic [ICG_CODE_W-1:0] c;
        c = '0;
        case (b)
            // R14: far slow and far fast
            ICG_BAND_SLOW_FAR: c = -ICG_STEP_BIG;
            ICG_BAND_FAST_FAR: c = ICG_STEP_BIG;
            // R15: middle bands
            ICG_BAND_SLOW_MID: c = -ICG_STEP_MID;
            ICG_BAND_FAST_MID: c = ICG_STEP_MID;
            // R16: near bands
            ICG_BAND_SLOW_NEAR: c = -ICG_STEP_FINE;
            ICG_BAND_FAST_NEAR: c = ICG_STEP_FINE;
            default: c = '0;
        endcase
        return c;
    endfunction

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic dco_rise;
        logic meas;
        logic int_rise;
        logic [ICG_MULT_W-1:0] half;
        logic base_div;
        logic [31:0] rd;
        logic [7:0] a;
        dco_rise = 1'b0;
        meas = 1'b0;
        int_rise = 1'b0;
        half = '0;
        base_div = 1'b0;
        rd = '0;
        a = '0;
        s_nxt = s_r;

        // synchronise asynchronous inputs
        s_nxt.controlled_oscillator = sync_step(s_r.controlled_oscillator, i_dco_raw);
        s_nxt.osc1 = sync_step(s_r.osc1, i_osc1_raw);
        s_nxt.done = sync_step(s_r.done, i_cmp_done_tgl);
        dco_rise = s_r.controlled_oscillator.filt & ~s_r.controlled_oscillator.prev;
        meas = s_r.done.filt ^ s_r.done.prev;

        // bus write in data phase
        if (s_r.ap_valid && s_r.ap_write) begin
            a = s_r.ap_addr;
            if (a == ICG_OFS_CTRL) begin
                s_nxt.int_on = i_hwdata[ICG_CTRL_INT_ON];
                // R7: external on settable only when allowed
                s_nxt.ext_on = i_hwdata[ICG_CTRL_EXT_ON]
                             & (s_r.ext_on | i_cfg.ext_clock_allowed);
                s_nxt.clk_sel = i_hwdata[ICG_CTRL_CLK_SEL];
            end else if (a == ICG_OFS_MULT) begin
                s_nxt.mult = i_hwdata[ICG_MULT_W-1:0];
            end else if (a == ICG_OFS_CODE) begin
                s_nxt.code = i_hwdata[ICG_CODE_W-1:0];
            end
        end

        // R22: one correction per finished measurement
        if (meas && int_en) begin
            // R13: add or subtract the chosen step
            // R17: plain 12-bit sum, carries ripple into divider
            // R19: no clamping, wrapped code walks back by steps
            s_nxt.code = s_nxt.code + corr_of(i_cmp_band);
            // R20: stable inside the five percent window
            // R22: cleared by any measurement outside it
            s_nxt.stable = (i_cmp_band == ICG_BAND_SLOW_NEAR)
                         | (i_cmp_band == ICG_BAND_FAST_NEAR);
        end
        if (!int_en) begin
            s_nxt.stable = 1'b0;
        end

        // R5: internal clock follows oscillator only while enabled
        s_nxt.clk.internal_clock = s_r.controlled_oscillator.filt & int_en;
        int_rise = dco_rise & int_en;

        // R10: modulo divider counts internal rising edges
        if (!int_en) begin
            s_nxt.div_cnt = '0;
        end else if (int_rise) begin
            if (s_r.div_cnt >= s_r.mult - 1'b1) begin
                s_nxt.div_cnt = '0;
            end else begin
                s_nxt.div_cnt = s_r.div_cnt + 1'b1;
            end
        end
        half = (s_r.mult >> 1) + {{(ICG_MULT_W-1){1'b0}}, s_r.mult[0]};
        base_div = (s_nxt.div_cnt < half);
        // R11: factor zero or one passes internal straight through
        if (s_r.mult <= {{(ICG_MULT_W-1){1'b0}}, 1'b1}) begin
            s_nxt.clk.base_clock = s_nxt.clk.internal_clock;
        end else begin
            // R5: base held low while disabled
            s_nxt.clk.base_clock = base_div & int_en;
        end

        // R6: external clock held low while disabled
        s_nxt.clk.external_clock = s_r.osc1.filt & ext_en;

        // R21: oscillator output source select
        s_nxt.clk.osc_out_clock = s_r.clk_sel ? s_nxt.clk.external_clock
                                              : s_nxt.clk.internal_clock;
        // R1: divide by two on oscillator output rising edges
        if (s_nxt.clk.osc_out_clock && !s_r.clk.osc_out_clock) begin
            s_nxt.clk.gen_out_clock = ~s_r.clk.gen_out_clock;
        end
        // timebase follows external whenever external is switched on
        s_nxt.clk.timebase_clock = s_r.ext_on ? s_nxt.clk.external_clock
                                              : s_nxt.clk.internal_clock;

        // bus address phase capture
        s_nxt.ap_valid = i_hsel & i_htrans[1] & i_hready;
        if (i_hready) begin
            s_nxt.ap_write = i_hwrite;
            s_nxt.ap_addr = i_haddr[7:0];
        end

        // read data of control, multiplier and code from post-write values, so back-to-back reads are fresh
        if (i_hsel && i_htrans[1] && i_hready && !i_hwrite) begin
            if (i_haddr[7:0] == ICG_OFS_CTRL) begin
                rd[ICG_CTRL_INT_ON] = s_nxt.int_on;
                rd[ICG_CTRL_EXT_ON] = s_nxt.ext_on;
                rd[ICG_CTRL_CLK_SEL] = s_nxt.clk_sel;
            end else if (i_haddr[7:0] == ICG_OFS_MULT) begin
                rd[ICG_MULT_W-1:0] = s_nxt.mult;
            end else if (i_haddr[7:0] == ICG_OFS_CODE) begin
                rd[ICG_CODE_W-1:0] = s_nxt.code;
            end else if (i_haddr[7:0] == ICG_OFS_STAT) begin
                rd[ICG_STAT_INT_EN] = int_en;
                rd[ICG_STAT_EXT_EN] = ext_en;
                rd[ICG_STAT_STABLE] = s_r.stable;
                rd[ICG_STAT_STOP] = gen_stop;
                rd[ICG_STAT_PC4] = ~s_r.ext_on;
                rd[ICG_STAT_PC3] = ~(s_r.ext_on & i_cfg.crystal_mode_enable);
            end
            s_nxt.rdata = rd;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            s_r <= '0;
            s_r.int_on <= ICG_INT_ON_RST;
            s_r.mult <= ICG_MULT_RST;
            s_r.code <= ICG_CODE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_hrdata = s_r.rdata;
    assign o_hreadyout = 1'b1;  // zero wait states
    assign o_hresp = 1'b0;      // always okay

    assign o_gen_stop_signal = gen_stop;
    assign o_int_gen_enable = int_en;
    assign o_ext_gen_enable = ext_en;
    // R8: pin C4 released to port only with external off
    assign o_pin_c4_port_enable = ~s_r.ext_on;
    // R9: pin C3 kept from port with external on in crystal mode
    assign o_pin_c3_port_enable = ~(s_r.ext_on & i_cfg.crystal_mode_enable);

    // R12: code split into divider nibble and stage byte
    assign o_osc_divider_code = s_r.code[11:8];
    assign o_osc_stage_code = s_r.code[7:0];
    // R18: divider nibbles above nine act as nine
    assign o_osc_divider_eff = (s_r.code[11:8] > ICG_DIV_SLOWEST)
                             ? ICG_DIV_SLOWEST : s_r.code[11:8];
    assign o_filter_stable_flag = s_r.stable;
    assign o_clk = s_r.clk;

endmodule // icg_ctrl

// File: bench/icg_ctrl_checker.sv
// port assertions for the clock generator control
`timescale 1ns/1ps

module icg_ctrl_checker
    import icg_pkg::*;
(
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // watched ports
    input wire logic i_stop_mode,
    input wire icg_cfg_s i_cfg,
    input wire logic o_gen_stop_signal,
    input wire logic o_int_gen_enable,
    input wire logic o_ext_gen_enable,
    input wire logic o_pin_c4_port_enable,
    input wire logic o_pin_c3_port_enable,
    input wire logic [3:0] o_osc_divider_code,
    input wire logic [3:0] o_osc_divider_eff,
    input wire logic o_filter_stable_flag,
    input wire icg_clk_s o_clk
);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    a_stop_level: assert property (
        o_gen_stop_signal == (i_stop_mode && !i_cfg.keep_osc_in_stop))
        else $error("stop signal level wrong");
    a_stop_gates: assert property (
        o_gen_stop_signal |-> !o_int_gen_enable && !o_ext_gen_enable)
        else $error("enable active in stop");
    a_int_off: assert property (
        !o_int_gen_enable ##1 !o_int_gen_enable
        |=> !o_clk.internal_clock && !o_clk.base_clock)
        else $error("internal clocks run while disabled");
    a_ext_off: assert property (
        !o_ext_gen_enable |=> !o_clk.external_clock)
        else $error("external clock runs while disabled");
    a_c4_free: assert property (
        o_ext_gen_enable |-> !o_pin_c4_port_enable)
        else $error("pin c4 port logic enabled");
    a_c3_pair: assert property (
        !o_pin_c3_port_enable
        |-> !o_pin_c4_port_enable && i_cfg.crystal_mode_enable)
        else $error("pin c3 port logic off without cause");
    a_slow_map: assert property (
        o_osc_divider_eff == ((o_osc_divider_code > 4'h9) ?
        4'h9 : o_osc_divider_code))
        else $error("divider code mapping wrong");
    a_half_rate: assert property (
        $rose(o_clk.osc_out_clock) |-> ##[0:2] $changed(o_clk.gen_out_clock))
        else $error("gen output missed a toggle");
    a_stable_off: assert property (
        !o_int_gen_enable |=> !o_filter_stable_flag)
        else $error("stable flag set while disabled");

    // main scenarios
    c_stop: cover property (o_gen_stop_signal);
    c_stable: cover property ($rose(o_filter_stable_flag));
    c_wrap: cover property (o_osc_divider_code > 4'h9);
endmodule // icg_ctrl_checker

bind icg_ctrl icg_ctrl_checker u_chk (.i_mclk, .i_rst_n, .i_stop_mode,
    .i_cfg, .o_gen_stop_signal, .o_int_gen_enable, .o_ext_gen_enable,
    .o_pin_c4_port_enable, .o_pin_c3_port_enable, .o_osc_divider_code,
    .o_osc_divider_eff, .o_filter_stable_flag, .o_clk);

// File: bench/icg_far_model.sv
// oscillator and frequency comparator model feeding the raw inputs
`timescale 1ns/1ps

module icg_far_model
    import icg_pkg::*;
#(
    parameter int DCO_HALF = 4,
    parameter int OSC_HALF = 5
)(
    // clock
    input wire logic i_mclk,
    // commands from the bench
    input wire logic i_req,
    input wire logic [2:0] i_band,
    // raw signals toward the block
    output logic o_dco_raw = 1'b0,
    output logic o_osc1_raw = 1'b0,
    output logic o_done_tgl = 1'b0,
    output logic [2:0] o_band = 3'h0
);
    int dcnt = 0;
    int ocnt = 0;
    logic req_q = 1'b0;

    // free running oscillators and one measurement per request
    always @(posedge i_mclk) begin
        dcnt <= (dcnt == DCO_HALF - 1) ? 0 : dcnt + 1;
        ocnt <= (ocnt == OSC_HALF - 1) ? 0 : ocnt + 1;
        if (dcnt == DCO_HALF - 1) o_dco_raw <= ~o_dco_raw;
        if (ocnt == OSC_HALF - 1) o_osc1_raw <= ~o_osc1_raw;
        req_q <= i_req;
        if (req_q != i_req) begin
            o_band <= i_band;
            o_done_tgl <= ~o_done_tgl;
        end
    end
endmodule // icg_far_model

// File: bench/test_internal_clock_gen_control.sv
// self-checking bench for the clock generator control
`timescale 1ns/1ps

module test_internal_clock_gen_control
    import icg_pkg::*;
();
    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic stop = 1'b0;
    logic req = 1'b0;
    logic [2:0] band = 3'h0;
    icg_cfg_s cfg = 3'h0;
    logic [31:0] hrdata, rd;
    logic hready, hresp, controlled_oscillator, osc1, tgl, gstop, int_en, ext_en;
    logic pc4, pc3, stable;
    logic [2:0] cband;
    logic [3:0] dcode, deff;
    logic [7:0] scode;
    logic [11:0] exp;
    icg_clk_s clks;
    int bad_count = 0;
    int checked = 0;
    logic [11:0] r_start [10] = '{12'h500, 12'h500, 12'h500, 12'h500,
        12'h500, 12'h500, 12'h9ff, 12'h000, 12'h0ff, 12'ha05};
    logic [2:0] r_band [10] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5,
        3'h5, 3'h0, 3'h3, 3'h1};

    icg_ctrl dut (.i_mclk(mclk), .i_rst_n(rst_n), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
        .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .i_stop_mode(stop), .i_cfg(cfg), .i_dco_raw(controlled_oscillator),
        .i_osc1_raw(osc1), .i_cmp_done_tgl(tgl), .i_cmp_band(cband),
        .o_gen_stop_signal(gstop), .o_int_gen_enable(int_en),
        .o_ext_gen_enable(ext_en), .o_pin_c4_port_enable(pc4),
        .o_pin_c3_port_enable(pc3), .o_osc_divider_code(dcode),
        .o_osc_stage_code(scode), .o_osc_divider_eff(deff),
        .o_filter_stable_flag(stable), .o_clk(clks));

    icg_far_model far (.i_mclk(mclk), .i_req(req), .i_band(band),
        .o_dco_raw(controlled_oscillator), .o_osc1_raw(osc1), .o_done_tgl(tgl),
        .o_band(cband));

    // clock
    initial forever #5 mclk = ~mclk;

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] want);
        checked++;
        if (got !== want) begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, got, want);
        end
    endtask

    // one single ahb transfer, read data left in rd
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge mclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge mclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge mclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task rdchk(input logic [7:0] a, input logic [31:0] want);
        bus(1'b0, a, 32'h0);
        chk(rd, want);
        chk(hresp, 1'b0);
    endtask

    task reset();
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
    endtask

    // one comparator result, then time for it to land
    task meas(input logic [2:0] b);
        @(posedge mclk);
        band <= b;
        req <= ~req;
        repeat (10) @(posedge mclk);
    endtask

    function logic [11:0] step(input logic [2:0] b);
        case (b)
            3'h0: step = 12'hfe0;
            3'h1: step = 12'hff8;
            3'h2: step = 12'hfff;
            3'h3: step = 12'h001;
            3'h4: step = 12'h008;
            default: step = 12'h020;
        endcase
    endfunction

    // internal rising edges within one base period
    task ratio(input logic [6:0] n, input int want);
        int cnt, seen;
        logic pi, pb;
        cnt = 0;
        seen = 0;
        pi = 1'b1;
        pb = 1'b1;
        bus(1'b1, ICG_OFS_MULT, {25'h0, n});
        repeat (80) @(posedge mclk);
        repeat (300) begin
            @(negedge mclk);
            if (seen == 1 && clks.internal_clock && !pi) cnt++;
            if (clks.base_clock && !pb) seen++;
            pi = clks.internal_clock;
            pb = clks.base_clock;
        end
        chk(cnt, want);
    endtask

    task end_sim();
        $display("checks %0d errors %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        reset();
        for (int i = 0; i < 10; i++) begin
            bus(1'b1, ICG_OFS_CODE, {20'h0, r_start[i]});
            meas(r_band[i]);
            exp = r_start[i] + step(r_band[i]);
            rdchk(ICG_OFS_CODE, {20'h0, exp});
            chk(deff, (exp[11:8] > 4'h9) ? 4'h9 : exp[11:8]);
            chk(dcode, exp[11:8]);
            chk(scode, exp[7:0]);
            chk(stable, r_band[i] inside {3'h2, 3'h3});
        end
        reset();
        rdchk(ICG_OFS_CTRL, 32'h1);
        rdchk(ICG_OFS_CODE, 32'h500);
        rdchk(ICG_OFS_STAT, 32'h31);
        bus(1'b1, 8'h10, 32'hffffffff);
        rdchk(8'h10, 32'h0);
        bus(1'b1, ICG_OFS_CTRL, 32'h3);
        rdchk(ICG_OFS_CTRL, 32'h1);
        cfg <= '{1'b0, 1'b1, 1'b1};
        bus(1'b1, ICG_OFS_CTRL, 32'h3);
        rdchk(ICG_OFS_STAT, 32'h03);
        stop <= 1'b1;
        rdchk(ICG_OFS_STAT, 32'h08);
        cfg <= '{1'b1, 1'b1, 1'b1};
        rdchk(ICG_OFS_STAT, 32'h03);
        stop <= 1'b0;
        bus(1'b1, ICG_OFS_CTRL, 32'h0);
        meas(3'h0);
        rdchk(ICG_OFS_CODE, 32'h500);
        rdchk(ICG_OFS_STAT, 32'h30);
        bus(1'b1, ICG_OFS_CTRL, 32'h1);
        ratio(7'h4, 4);
        ratio(7'h3, 3);
        ratio(7'h1, 1);
        ratio(7'h0, 1);
        // source select: external with select set, internal without
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, ICG_OFS_CTRL, k ? 32'h1 : 32'h7);
            repeat (20) @(posedge mclk);
            repeat (24) begin
                @(negedge mclk);
                chk(clks.osc_out_clock, k ? clks.internal_clock
                    : clks.external_clock);
            end
        end
        end_sim();
    end

    // watchdog
    initial begin
        repeat (10000) @(posedge mclk);
        bad_count++;
        end_sim();
    end
endmodule // test_internal_clock_gen_control
